/* mim_irq_top.sv */
// Purpose: transmit interrupt enables and combined pending vector
// Assumes: apb master holds request until pready; sources on sys clock
// Notes:   one wait-free answer; read data sampled in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module mim_irq_top
    import mim_pkg::*;
(
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_b_in,
    input  wire mim_apb_req_type         apb_req_in,
    input  wire logic [MIM_CHANNELS-1:0] tx_event_in,
    input  wire mim_src_type             src_in,
    output logic      [31:0]             prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    output logic                         irq_out
);

    mim_state_type           state_r;
    mim_state_type           state_nxt;
    logic [MIM_CHANNELS-1:0] enable;
    logic [MIM_CHANNELS-1:0] flags;
    logic [MIM_CHANNELS-1:0] en_set;
    logic [MIM_CHANNELS-1:0] en_clr;
    logic [MIM_CHANNELS-1:0] flag_clr;
    logic [MIM_CHANNELS-1:0] wdata_ch;
    logic [31:0]             vector;
    logic [31:0]             rdata;
    logic                    setup;
    logic                    access;
    logic                    hit_en;
    logic                    hit_dis;
    logic                    hit_vec;
    logic                    hit_stat;
    logic                    hit_any;
    logic                    wr_en;
    logic                    wr_dis;
    logic                    wr_stat;

    // apb phases; access only counts on the edge where pready is high
    assign setup  = apb_req_in.psel & ~apb_req_in.penable;
    assign access = apb_req_in.psel & apb_req_in.penable & state_r.pready;

    // address decode, full byte address so misaligned is unmapped
    assign hit_en   = (apb_req_in.paddr == MIM_ADDR_TX_EN);
    assign hit_dis  = (apb_req_in.paddr == MIM_ADDR_TX_DIS);
    assign hit_vec  = (apb_req_in.paddr == MIM_ADDR_VECTOR);
    assign hit_stat = (apb_req_in.paddr == MIM_ADDR_TX_STAT);
    assign hit_any  = hit_en | hit_dis | hit_vec | hit_stat;

    // write strobes; writes to the vector are silently dropped
    assign wr_en    = access & apb_req_in.pwrite & hit_en;
    assign wr_dis   = access & apb_req_in.pwrite & hit_dis;
    assign wr_stat  = access & apb_req_in.pwrite & hit_stat;
    assign wdata_ch = apb_req_in.pwdata[MIM_CHANNELS-1:0]; // see RL4

    // set and clear act on one shared enable per channel
    assign en_set   = wr_en  ? wdata_ch : '0;           // see RL7
    assign en_clr   = wr_dis ? wdata_ch : '0;           // see RL1 see RL2
    assign flag_clr = wr_stat ? wdata_ch : '0;

    // shared transmit enables, zero after reset
    mim_bit_bank #(
        .RESET_VAL (MIM_EN_RST)
    ) u_enable (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .set_in     (en_set),
        .clr_in     (en_clr),
        .bits_out   (enable)
    );

    // raw sticky transmit flags, kept even while disabled
    mim_bit_bank #(
        .RESET_VAL (MIM_FLAG_RST)
    ) u_flags (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .set_in     (tx_event_in),                      // see RL11
        .clr_in     (flag_clr),
        .bits_out   (flags)
    );

    // combined vector, every source in one word
    always_comb begin
        vector                   = '0;                  // see RL4
        vector[MIM_VEC_USER_BIT] = src_in.user_access_irq;  // see RL8
        vector[MIM_VEC_LINK_BIT] = src_in.link_change_irq;
        vector[MIM_VEC_HOST_BIT] = src_in.host_error_pending; // see RL9
        vector[MIM_VEC_STAT_BIT] = src_in.statistics_pending;
        vector[MIM_VEC_RX_LSB +: MIM_CHANNELS] =
            src_in.receive_channel_pending;             // see RL10
        vector[MIM_VEC_TX_LSB +: MIM_CHANNELS] =
            flags & enable;                             // see RL5 see RL6
    end

    // read mux; narrow registers zero-extended
    always_comb begin
        rdata = '0;
        if (hit_en || hit_dis) begin
            rdata[MIM_CHANNELS-1:0] = enable;           // see RL3
        end else if (hit_vec) begin
            rdata = vector;
        end else if (hit_stat) begin
            rdata[MIM_CHANNELS-1:0] = flags;
        end
    end

    // next state; ready is raised in setup so access ends at once
    always_comb begin
        state_nxt         = state_r;
        state_nxt.pready  = setup;
        state_nxt.pslverr = setup & ~hit_any;
        if (setup && !apb_req_in.pwrite) begin
            state_nxt.prdata = rdata;
        end
        // registered from banks, one cycle behind the flags
        state_nxt.irq = |(flags & enable);              // see RL11
    end

    // synchronous active-low reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_r <= MIM_STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata_out  = state_r.prdata;
    assign pready_out  = state_r.pready;
    assign pslverr_out = state_r.pslverr;
    assign irq_out     = state_r.irq;

    // checks and coverage on the design's own internal state and outputs
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // a disable write with ones clears exactly those enables
    dis_clear_bits_a: assert property ( // see RL1
        wr_dis |=> ((enable & $past(wdata_ch)) == '0))
        else $error("disable write left enable set");

    // zero bits leave the others untouched
    dis_keep_others_a: assert property ( // see RL2
        wr_dis |=> ((enable & ~$past(wdata_ch)) ==
                    ($past(enable) & ~$past(wdata_ch))))
        else $error("disable write disturbed other channels");

    // enable write sets the shared bit seen through both addresses
    // the read setup may come one edge after the write access; this check covers the bench's setup two edges after
    en_set_shared_a: assert property ( // see RL7
        wr_en ##2 (setup && !apb_req_in.pwrite && hit_dis)
        |=> ((prdata_out[MIM_CHANNELS-1:0] & $past(wdata_ch, 3))
             == $past(wdata_ch, 3)))
        else $error("set not visible in disable register");

    // disable register read returns live enables
    dis_read_val_a: assert property ( // see RL3
        (access && !apb_req_in.pwrite && hit_dis) |->
        (prdata_out == {24'h00_0000, enable}))
        else $error("disable register read mismatch");

    // enables come up cleared after reset
    en_reset_zero_a: assert property ( // see RL3
        $rose(rst_b_in) |-> (enable == MIM_EN_RST))
        else $error("enables not zero after reset");

    // reserved vector bits stay zero on every read
    rsv_bits_zero_a: assert property ( // see RL4
        (pready_out && hit_vec && !apb_req_in.pwrite) |->
        (prdata_out[29:18] == 12'h000))
        else $error("reserved vector bits set");

    // vector fields carry the sources sampled in setup
    vec_fields_map_a: assert property ( // see RL8
        (setup && hit_vec && !apb_req_in.pwrite) |=>
        (prdata_out[MIM_VEC_USER_BIT] == $past(src_in.user_access_irq)) &&
        (prdata_out[MIM_VEC_LINK_BIT] == $past(src_in.link_change_irq)) &&
        (prdata_out[MIM_VEC_HOST_BIT] == $past(src_in.host_error_pending))
        && (prdata_out[MIM_VEC_STAT_BIT] ==
            $past(src_in.statistics_pending)))
        else $error("vector source bits misplaced");

    // channel fields of the vector
    vec_chan_map_a: assert property ( // see RL10
        (setup && hit_vec && !apb_req_in.pwrite) |=>
        (prdata_out[15:8] == $past(src_in.receive_channel_pending)) &&
        (prdata_out[7:0] == $past(flags & enable)))
        else $error("vector channel bits misplaced");

    // a read with any transmit pending never shows an empty transmit field
    vec_all_seen_a: assert property ( // see RL5 see RL6
        (setup && hit_vec && !apb_req_in.pwrite && (flags & enable) != '0)
        |=> (prdata_out[7:0] != 8'h00))
        else $error("pending channel missing from vector");

    // raw flag survives while its channel is disabled
    flag_kept_a: assert property ( // see RL11
        (tx_event_in[0] && !enable[0]) |=> flags[0])
        else $error("raw flag lost while disabled");

    // other channels may be pending, so judge the output on all of them
    irq_masked_a: assert property ( // see RL11
        ((flags & enable) == '0) |=> !irq_out)
        else $error("disabled pending leaked to output");

    // output follows enabled flags one cycle later
    irq_gate_a: assert property ( // see RL11
        ((flags & enable) != '0) |=> irq_out)
        else $error("enabled pending did not raise interrupt");

    // answer is one cycle wide and follows setup directly
    ready_timing_a: assert property (
        setup |=> pready_out ##1 !pready_out)
        else $error("apb ready timing wrong");

    // unmapped addresses answer with an error
    unmapped_err_a: assert property (
        (setup && !hit_any) |=> (pready_out && pslverr_out))
        else $error("unmapped access not flagged");

    // main scenarios
    disable_write_c: cover property (
        wr_dis ##1 (enable != '0));
    masked_event_c: cover property (
        ((tx_event_in & ~enable) != '0) ##1 (flags != '0));
    vector_read_c: cover property (
        (access && hit_vec && !apb_req_in.pwrite && prdata_out != '0));
    irq_raise_c: cover property (
        !irq_out ##1 irq_out);

endmodule
`default_nettype wire

/* mim_pkg.sv */
// Purpose: constants and carrier types for the mac interrupt mask block
// Assumes: apb slave with 32-bit data, one 50 MHz clock
// Notes:   addresses are byte addresses, each register one aligned word
//
// Summary of operation
// RL1: writing 1 to disable bit clears enable
// RL2: writing 0 to disable bit changes nothing
// RL3: disable register reads enables, reset zero
// RL4: reserved bits read zero, writes ignored
// RL5: read-only vector shows all pending interrupts
// RL6: one vector read reveals every source
// RL7: enable-set register sets same shared enable
// RL8: vector bit 31 user, 30 link
// RL9: vector bit 17 host error, 16 statistics
// RL10: bits 15..8 receive, 7..0 transmit channels
// RL11: output gated by enable, raw flag kept
package mim_pkg;

    localparam int MIM_CHANNELS = 8;
    localparam int MIM_ADDR_W   = 8;

    // register byte addresses
    localparam logic [7:0] MIM_ADDR_TX_EN   = 8'h00;
    localparam logic [7:0] MIM_ADDR_TX_DIS  = 8'h04;
    localparam logic [7:0] MIM_ADDR_VECTOR  = 8'h08;
    localparam logic [7:0] MIM_ADDR_TX_STAT = 8'h0c;

    // combined vector field positions
    localparam int MIM_VEC_USER_BIT = 31;
    localparam int MIM_VEC_LINK_BIT = 30;
    localparam int MIM_VEC_HOST_BIT = 17;
    localparam int MIM_VEC_STAT_BIT = 16;
    localparam int MIM_VEC_RX_LSB   = 8;
    localparam int MIM_VEC_TX_LSB   = 0;

    // reset values
    localparam logic [7:0]  MIM_EN_RST     = 8'h00;
    localparam logic [7:0]  MIM_FLAG_RST   = 8'h00;
    localparam logic [31:0] MIM_PRDATA_RST = 32'h0000_0000;

    // apb request from the master
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [MIM_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } mim_apb_req_type;

    // pending levels from the other interrupt sources
    typedef struct packed {
        logic                    user_access_irq;
        logic                    link_change_irq;
        logic                    host_error_pending;
        logic                    statistics_pending;
        logic [MIM_CHANNELS-1:0] receive_channel_pending;
    } mim_src_type;

    // registered state of the top module
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } mim_state_type;

    // registered state of one bit bank
    typedef struct packed {
        logic [MIM_CHANNELS-1:0] bits;
    } mim_bank_type;

    localparam mim_state_type MIM_STATE_RST = '{
        prdata:  MIM_PRDATA_RST,
        pready:  1'b0,
        pslverr: 1'b0,
        irq:     1'b0
    };

endpackage

/* mim_bit_bank.sv */
// Purpose: bank of per-channel set/clear bits
// Assumes: set and clear come from logic on the same clock
// Notes:   set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module mim_bit_bank
    import mim_pkg::*;
#(
    parameter logic [MIM_CHANNELS-1:0] RESET_VAL = MIM_FLAG_RST
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic [MIM_CHANNELS-1:0] set_in,
    input  wire logic [MIM_CHANNELS-1:0] clr_in,
    output logic      [MIM_CHANNELS-1:0] bits_out
);

    mim_bank_type            bank_r;
    mim_bank_type            bank_nxt;
    logic [MIM_CHANNELS-1:0] bit_nxt;

    // per bit: an arriving set is never lost to a clear
    genvar gi;
    generate
        for (gi = 0; gi < MIM_CHANNELS; gi++) begin : g_bit
            assign bit_nxt[gi] = set_in[gi] | (bank_r.bits[gi] & ~clr_in[gi]);
        end
    endgenerate

    // copy of state
    always_comb begin
        bank_nxt      = bank_r;
        bank_nxt.bits = bit_nxt;
    end

    // synchronous reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            bank_r.bits <= RESET_VAL;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    assign bits_out = bank_r.bits;

    // set beats clear, clear alone drops only its own bits
    set_wins_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        |set_in |=> ((bank_r.bits & $past(set_in)) == $past(set_in)))
        else $error("bank set lost");
    clr_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        (|clr_in && set_in == '0) |=>
        (bank_r.bits == ($past(bank_r.bits) & ~$past(clr_in))))
        else $error("bank clear wrong");

endmodule
`default_nettype wire

/* mac_irq_mask_and_vector_tb.sv */
// Purpose: self-checking bench for the mac interrupt mask block
// Assumes: apb answer comes within a few cycles, one 50 MHz clock
// Notes:   the master waits for pready, a watchdog bounds every wait
`timescale 1ns/1ps
`default_nettype none
module mac_irq_mask_and_vector_tb
    import mim_pkg::*;
;
    logic                    sys_clk;
    logic                    rst_b;
    mim_apb_req_type         apb_req;
    logic [MIM_CHANNELS-1:0] tx_event;
    mim_src_type             src;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
    int                      errors;
    int                      n_checks;
    int                      k;
    logic [31:0]             rd_data;
    logic                    rd_err;
    logic [11:0]             pats [6] = '{12'h800, 12'h400, 12'h200,
                                          12'h100, 12'h0a5, 12'hfff};

    mim_irq_top uut (
        .sys_clk_in  (sys_clk),
        .rst_b_in    (rst_b),
        .apb_req_in  (apb_req),
        .tx_event_in (tx_event),
        .src_in      (src),
        .prdata_out  (prdata),
        .pready_out  (pready),
        .pslverr_out (pslverr),
        .irq_out     (irq)
    );

    // free-running 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // one comparison, counted; x never passes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // apb transfer; ready, data and error all taken at the rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata);
        rd_data = 'x;
        rd_err  = 1'bx;
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        // no fixed latency assumed; only the watchdog ends a stuck wait
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd_data = prdata;
        rd_err  = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        // idle edge so the next setup never lands in the same time step
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 32'h0000_0000);
        chk(rd_data, exp);
        chk({31'h0, rd_err}, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] d);
        xfer(1'b1, addr, d);
        chk({31'h0, rd_err}, 32'h0000_0000);
    endtask

    // interrupt level checked where it is settled
    task automatic irq_chk(input logic exp);
        @(negedge sys_clk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge sys_clk);
    endtask

    task automatic complete_run;
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        complete_run();
    end

    // main sequence
    initial begin
        errors   = 0;
        n_checks = 0;
        rst_b    = 1'b0;
        apb_req  = '0;
        tx_event = '0;
        src      = '0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        irq_chk(1'b0);
        rd(MIM_ADDR_TX_DIS, 32'h0000_0000);
        rd(MIM_ADDR_TX_EN, 32'h0000_0000);
        rd(MIM_ADDR_VECTOR, 32'h0000_0000);
        // reserved bits written as ones must not read back
        wr(MIM_ADDR_TX_EN, 32'hffff_ffff);
        rd(MIM_ADDR_TX_DIS, 32'h0000_00ff);
        wr(MIM_ADDR_TX_DIS, 32'hffff_ff05);
        rd(MIM_ADDR_TX_DIS, 32'h0000_00fa);
        rd(MIM_ADDR_TX_EN, 32'h0000_00fa);
        // events on channels 0 and 1; only channel 1 still enabled
        tx_event <= 8'h03;
        @(posedge sys_clk);
        tx_event <= 8'h00;
        @(posedge sys_clk);
        irq_chk(1'b1);
        rd(MIM_ADDR_VECTOR, 32'h0000_0002);
        rd(MIM_ADDR_TX_STAT, 32'h0000_0003);
        wr(MIM_ADDR_TX_DIS, 32'h0000_0002);
        irq_chk(1'b0);
        rd(MIM_ADDR_VECTOR, 32'h0000_0000);
        rd(MIM_ADDR_TX_STAT, 32'h0000_0003);
        wr(MIM_ADDR_TX_EN, 32'h0000_0001);
        rd(MIM_ADDR_VECTOR, 32'h0000_0001);
        irq_chk(1'b1);
        wr(MIM_ADDR_TX_STAT, 32'h0000_0003);
        irq_chk(1'b0);
        rd(MIM_ADDR_TX_DIS, 32'h0000_00f9);
        // user, link, host error and statistics alone, receive pattern 0xa5, then all together
        for (k = 0; k < 6; k++) begin
            src <= pats[k];
            rd(MIM_ADDR_VECTOR,
               {pats[k][11:10], 12'h000, pats[k][9:0], 8'h00});
        end
        // the vector is read-only, a write leaves it as it was
        wr(MIM_ADDR_VECTOR, 32'h0000_0000);
        rd(MIM_ADDR_VECTOR, 32'hc003_ff00);
        // unmapped address is refused and has no effect
        xfer(1'b1, 8'h10, 32'hffff_ffff);
        chk({31'h0, rd_err}, 32'h0000_0001);
        rd(MIM_ADDR_TX_DIS, 32'h0000_00f9);
        complete_run();
    end
endmodule
`default_nettype wire
